// [rtl/adc_defines.vh]
// register map, field positions and reset values of the converter control block
`ifndef ADC_DEFINES_VH
`define ADC_DEFINES_VH

// ****************************************
// register byte offsets
// ****************************************
`define OFF_CHANNEL_CONTROL 8'h00
`define OFF_PORT_REF_CONFIG 8'h04
`define OFF_TIMING_FORMAT 8'h08
`define OFF_RESULT_HIGH 8'h0c
`define OFF_RESULT_LOW 8'h10
`define OFF_IRQ_STATUS 8'h14
`define OFF_IRQ_CLEAR 8'h18
`define OFF_IRQ_ENABLE 8'h1c

// ****************************************
// channel control fields
// ****************************************
`define CC_CAL_BIT 7
`define CC_CHS_HI 5
`define CC_CHS_LO 2
`define CC_GO_BIT 1
`define CC_EN_BIT 0
`define CC_WRITE_MASK 8'hbf

// ****************************************
// port and reference config fields
// ****************************************
`define PR_NEG_REF_BIT 5
`define PR_POS_REF_BIT 4
`define PR_PCFG_HI 3
`define PR_PCFG_LO 0
`define PR_WRITE_MASK 8'h3f

// ****************************************
// timing and format fields
// ****************************************
`define TF_JUSTIFY_BIT 7
`define TF_ACQ_HI 5
`define TF_ACQ_LO 3
`define TF_CLK_HI 2
`define TF_CLK_LO 0
`define TF_WRITE_MASK 8'hbf

// ****************************************
// interrupt bits
// ****************************************
`define IRQ_DONE_BIT 0
`define IRQ_CAL_BIT 1
`define IRQ_MASK 2'h3

// ****************************************
// reset values
// ****************************************
`define RST_CHANNEL_CONTROL 8'h00
`define RST_PORT_REF_CONFIG 8'h00
`define RST_TIMING_FORMAT 8'h00
`define RST_IRQ 2'h0
`define RST_PINS_LARGE 16'hffdf
`define RST_PINS_SMALL 16'h0fdf

// ****************************************
// channel codes
// ****************************************
`define CHS_UNUSED 4'h5
`define CHS_LAST_SMALL 4'hb
`define CHS_LAST_LARGE 4'hc

`endif

// [rtl/pin_config_decode.v]
// decodes the pin configuration code into a per-pin analog mask
`timescale 1ns/1ps
`default_nettype none
module pin_config_decode #(
	parameter LARGE_PKG = 1
) (
	input wire [3:0] pin_analog_config,
	output wire [15:0] pin_analog
);
	// number of analog inputs, counted from the lowest, for each code
	function [3:0] analog_count;
		input [3:0] code;
		begin
			case (code)
				4'h0: analog_count = 4'hf;
				4'h9, 4'ha: analog_count = 4'h5;
				default: begin
					if (code < 4'h9) begin
						analog_count = 4'he - code;
					end else begin
						analog_count = 4'hf - code;
					end
				end
			endcase
		end
	endfunction

	wire [3:0] count = analog_count(pin_analog_config);
	assign pin_analog[5] = 1'b0;

	genvar i;
	generate
		for (i = 0; i < 15; i = i + 1) begin : g_pin
			localparam integer PIN = (i < 5) ? i : i + 1;
			localparam integer PRESENT = (PIN < 12) || (LARGE_PKG != 0);
			assign pin_analog[PIN] = (PRESENT != 0) && (i < count);
		end
	endgenerate
endmodule // pin_config_decode
`default_nettype wire

// [rtl/result_format.v]
// holds the 10-bit result and presents it justified across the register pair
`timescale 1ns/1ps
`default_nettype none
module result_format (
	input wire pclk,
	input wire load,
	input wire [9:0] result_in,
	input wire right_justify,
	output wire [7:0] result_high,
	output wire [7:0] result_low
);
	// no reset: a device reset leaves the result pair untouched
	reg [9:0] result_r;

	always @(posedge pclk) begin
		if (load) begin
			result_r <= result_in;
		end
	end

	assign result_high = right_justify ? {6'h00, result_r[9:8]} : result_r[9:2];
	assign result_low = right_justify ? result_r[7:0] : {result_r[1:0], 6'h00};
endmodule // result_format
`default_nettype wire

// [rtl/adc_ctrl.v]
// converter control front end: apb registers, conversion sequencing and analog core controls
`timescale 1ns/1ps
`default_nettype none
`include "adc_defines.vh"
module adc_ctrl #(
	parameter LARGE_PKG = 1
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	output wire irq,
	output wire core_enable,
	output reg core_start,
	output wire [3:0] core_channel,
	output wire core_channel_valid,
	output wire core_calibrate,
	output wire neg_ref_select,
	output wire pos_ref_select,
	output wire [2:0] acq_time_select,
	output wire [2:0] conv_clock_select,
	output wire [15:0] pin_analog,
	input wire core_done,
	input wire [9:0] core_result
);
	// ****************************************
	// constants
	// ****************************************
	localparam [3:0] NUM_INPUTS = (LARGE_PKG != 0) ? 4'd15 : 4'd11;
	localparam [3:0] LAST_CODE = (LARGE_PKG != 0) ? `CHS_LAST_LARGE : `CHS_LAST_SMALL;
	// every present pin analog, as code zero
	localparam [15:0] PINS_RESET = (LARGE_PKG != 0) ? `RST_PINS_LARGE : `RST_PINS_SMALL;

	localparam [1:0] ST_IDLE = 2'd0;
	localparam [1:0] ST_START = 2'd1;
	localparam [1:0] ST_BUSY = 2'd2;

	// ****************************************
	// helpers
	// ****************************************
	// true when a channel code routes a real input on this package
	function chan_valid;
		input [3:0] code;
		begin
			chan_valid = (code != `CHS_UNUSED) && (code <= LAST_CODE);
		end
	endfunction

	// true when the access hits the given offset
	function hit;
		input [7:0] addr;
		input [7:0] off;
		begin
			hit = (addr == off);
		end
	endfunction

	// ****************************************
	// registers
	// ****************************************
	reg cal_r;
	reg cal_nxt;
	reg [3:0] chs_r;
	reg [3:0] chs_nxt;
	reg en_r;
	reg en_nxt;
	reg [5:0] prc_r;
	reg [5:0] prc_nxt;
	reg [7:0] tf_r;
	reg [7:0] tf_nxt;
	reg [1:0] irq_st_r;
	reg [1:0] irq_st_nxt;
	reg [1:0] irq_en_r;
	reg [1:0] irq_en_nxt;
	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg cal_run_r;
	reg cal_run_nxt;
	reg start_nxt;
	reg load_result;
	reg [31:0] rdata_nxt;

	// registered outputs
	reg [15:0] pin_analog_r;
	reg chan_valid_r;
	reg irq_r;

	wire [7:0] result_high;
	wire [7:0] result_low;
	wire [15:0] pin_decoded;

	// ****************************************
	// apb decode
	// ****************************************
	wire setup_ph = psel && !penable;
	wire access_ph = psel && penable;
	wire wr = access_ph && pwrite;
	wire [7:0] wbyte = pwdata[7:0];
	wire [7:0] pr_masked = wbyte & `PR_WRITE_MASK;

	wire addr_ok = hit(paddr, `OFF_CHANNEL_CONTROL) || hit(paddr, `OFF_PORT_REF_CONFIG)
		|| hit(paddr, `OFF_TIMING_FORMAT) || hit(paddr, `OFF_RESULT_HIGH)
		|| hit(paddr, `OFF_RESULT_LOW) || hit(paddr, `OFF_IRQ_STATUS)
		|| hit(paddr, `OFF_IRQ_CLEAR) || hit(paddr, `OFF_IRQ_ENABLE);

	assign pready = 1'b1;
	assign pslverr = access_ph && !addr_ok;

	wire wr_cc = wr && hit(paddr, `OFF_CHANNEL_CONTROL);
	wire wr_pr = wr && hit(paddr, `OFF_PORT_REF_CONFIG);
	wire wr_tf = wr && hit(paddr, `OFF_TIMING_FORMAT);
	wire wr_clr = wr && hit(paddr, `OFF_IRQ_CLEAR);
	wire wr_ien = wr && hit(paddr, `OFF_IRQ_ENABLE);

	wire busy = (state_r != ST_IDLE);
	// a done strobe outside a busy conversion is stale and ignored
	wire done_ev = core_done && (state_r == ST_BUSY);

	// ****************************************
	// control register and sequencer
	// ****************************************
	always @* begin
		cal_nxt = cal_r;
		chs_nxt = chs_r;
		en_nxt = en_r;
		prc_nxt = prc_r;
		tf_nxt = tf_r;
		irq_en_nxt = irq_en_r;
		state_nxt = state_r;
		cal_run_nxt = cal_run_r;
		start_nxt = 1'b0;
		load_result = 1'b0;

		if (done_ev && cal_run_r) begin
			cal_nxt = 1'b0;
		end
		// software write beats the hardware clear
		if (wr_cc) begin
			cal_nxt = wbyte[`CC_CAL_BIT];
			chs_nxt = wbyte[`CC_CHS_HI:`CC_CHS_LO];
			en_nxt = wbyte[`CC_EN_BIT];
		end
		if (wr_pr) begin
			prc_nxt = pr_masked[5:0];
		end
		if (wr_tf) begin
			tf_nxt = wbyte & `TF_WRITE_MASK;
		end
		if (wr_ien) begin
			irq_en_nxt = wbyte[1:0] & `IRQ_MASK;
		end

		case (state_r)
			ST_IDLE: begin
				if (wr_cc && wbyte[`CC_GO_BIT] && wbyte[`CC_EN_BIT]) begin
					state_nxt = ST_START;
					start_nxt = 1'b1;
					cal_run_nxt = wbyte[`CC_CAL_BIT];
				end
			end
			ST_START: begin
				state_nxt = ST_BUSY;
			end
			ST_BUSY: begin
				if (done_ev) begin
					state_nxt = ST_IDLE;
					load_result = 1'b1;
					cal_run_nxt = 1'b0;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase

		// turning the module off abandons the conversion
		if (!en_nxt) begin
			state_nxt = ST_IDLE;
			start_nxt = 1'b0;
			cal_run_nxt = 1'b0;
		end
	end

	// ****************************************
	// interrupt status
	// ****************************************
	always @* begin
		irq_st_nxt = irq_st_r;
		if (wr_clr) begin
			irq_st_nxt = irq_st_nxt & ~(wbyte[1:0] & `IRQ_MASK);
		end
		// a new event beats a clear in the same cycle
		if (done_ev) begin
			irq_st_nxt[`IRQ_DONE_BIT] = 1'b1;
		end
		if (done_ev && cal_run_r) begin
			irq_st_nxt[`IRQ_CAL_BIT] = 1'b1;
		end
	end

	assign irq = irq_r;

	// ****************************************
	// read data
	// ****************************************
	always @* begin
		rdata_nxt = 32'h0000_0000;
		case (paddr)
			`OFF_CHANNEL_CONTROL: begin
				rdata_nxt[`CC_CAL_BIT] = cal_r;
				rdata_nxt[`CC_CHS_HI:`CC_CHS_LO] = chs_r;
				rdata_nxt[`CC_GO_BIT] = en_r && busy;
				rdata_nxt[`CC_EN_BIT] = en_r;
			end
			`OFF_PORT_REF_CONFIG: begin
				rdata_nxt[5:0] = prc_r;
			end
			`OFF_TIMING_FORMAT: begin
				rdata_nxt[7:0] = tf_r;
			end
			`OFF_RESULT_HIGH: begin
				rdata_nxt[7:0] = result_high;
			end
			`OFF_RESULT_LOW: begin
				rdata_nxt[7:0] = result_low;
			end
			`OFF_IRQ_STATUS: begin
				rdata_nxt[1:0] = irq_st_r;
			end
			`OFF_IRQ_ENABLE: begin
				rdata_nxt[1:0] = irq_en_r;
			end
			default: begin
				rdata_nxt = 32'h0000_0000;
			end
		endcase
	end

	// ****************************************
	// flip-flops
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cal_r <= 1'b0;
			chs_r <= 4'h0;
			en_r <= 1'b0;
			prc_r <= 6'h00;
			tf_r <= `RST_TIMING_FORMAT;
			irq_st_r <= `RST_IRQ;
			irq_en_r <= `RST_IRQ;
			state_r <= ST_IDLE;
			cal_run_r <= 1'b0;
			core_start <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			cal_r <= cal_nxt;
			chs_r <= chs_nxt;
			en_r <= en_nxt;
			prc_r <= prc_nxt;
			tf_r <= tf_nxt;
			irq_st_r <= irq_st_nxt;
			irq_en_r <= irq_en_nxt;
			state_r <= state_nxt;
			cal_run_r <= cal_run_nxt;
			core_start <= start_nxt;
			if (setup_ph) begin
				prdata <= rdata_nxt;
			end
		end
	end

	// ****************************************
	// output registers
	// ****************************************
	// loaded from next values so outputs move on the same edge as their sources
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_analog_r <= PINS_RESET;
			chan_valid_r <= 1'b1;
			irq_r <= 1'b0;
		end else begin
			pin_analog_r <= pin_decoded;
			chan_valid_r <= chan_valid(chs_nxt) && (NUM_INPUTS != 4'd0);
			irq_r <= |(irq_st_nxt & irq_en_nxt);
		end
	end

	// ****************************************
	// analog core controls
	// ****************************************
	assign core_enable = en_r;
	assign core_channel = chs_r;
	assign core_channel_valid = chan_valid_r;
	assign pin_analog = pin_analog_r;
	assign core_calibrate = cal_r;
	assign neg_ref_select = prc_r[`PR_NEG_REF_BIT];
	assign pos_ref_select = prc_r[`PR_POS_REF_BIT];
	assign acq_time_select = tf_r[`TF_ACQ_HI:`TF_ACQ_LO];
	assign conv_clock_select = tf_r[`TF_CLK_HI:`TF_CLK_LO];

	pin_config_decode #(
		.LARGE_PKG(LARGE_PKG)
	) u_pin_decode (
		.pin_analog_config(prc_nxt[`PR_PCFG_HI:`PR_PCFG_LO]),
		.pin_analog(pin_decoded)
	);

	result_format u_result (
		.pclk(pclk),
		.load(load_result),
		.result_in(core_result),
		.right_justify(tf_r[`TF_JUSTIFY_BIT]),
		.result_high(result_high),
		.result_low(result_low)
	);
endmodule // adc_ctrl
`default_nettype wire

// [sim/core_model.sv]
// behavioural analog core answering each start with a delayed done strobe
`timescale 1ns/1ps
`default_nettype none
module core_model #(
	parameter int DLY = 6
) (
	input wire logic pclk,
	input wire logic core_start,
	input wire logic [3:0] core_channel,
	output logic core_done,
	output logic [9:0] core_result
);
	int cnt = 0;
	initial begin
		core_done = 1'b0;
		core_result = 10'h2aa;
	end
	always @(posedge pclk) begin
		core_done <= 1'b0;
		// result lines only hold their value with the strobe
		core_result <= ~core_result;
		if (core_start)
			cnt <= DLY;
		else if (cnt != 0)
			cnt <= cnt - 1;
		if (cnt == 1 && !core_start) begin
			core_done <= 1'b1;
			core_result <= {core_channel, 6'h15};
		end
	end
endmodule // core_model
`default_nettype wire

// [sim/adc_ctrl_properties.sv]
// port assertions for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_properties #(
	parameter int LARGE_PKG = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic core_enable,
	input wire logic core_start,
	input wire logic neg_ref_select,
	input wire logic pos_ref_select,
	input wire logic [15:0] pin_analog
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic wr0;
	logic wr4;
	assign wr0 = psel && penable && pwrite && paddr == 8'h00;
	assign wr4 = psel && penable && pwrite && paddr == 8'h04;
	a_start_one_cycle: assert property (core_start |=> !core_start)
		else $error("start pulse too long");
	a_start_enabled: assert property (core_start |-> core_enable)
		else $error("start while disabled");
	a_start_after_write: assert property (core_start |-> $past(wr0 && pwdata[1:0] == 2'b11))
		else $error("start without go write");
	a_enable_follows: assert property (wr0 |=> core_enable == $past(pwdata[0]))
		else $error("enable not taken");
	a_neg_ref: assert property (wr4 |=> neg_ref_select == $past(pwdata[5]))
		else $error("negative reference wrong");
	a_pos_ref: assert property (wr4 |=> pos_ref_select == $past(pwdata[4]))
		else $error("positive reference wrong");
	a_unused_pin: assert property (pin_analog[5] == 1'b0)
		else $error("unused pin analog");
	a_all_analog: assert property (wr4 && pwdata[3:0] == 4'h0 |=> pin_analog == ((LARGE_PKG != 0) ? 16'hffdf : 16'h0fdf))
		else $error("code zero mask wrong");
	a_all_digital: assert property (wr4 && pwdata[3:0] == 4'hf |=> pin_analog == 16'h0000)
		else $error("code fifteen mask wrong");
endmodule // adc_ctrl_properties
bind adc_ctrl adc_ctrl_properties #(.LARGE_PKG(LARGE_PKG)) chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .core_enable(core_enable), .core_start(core_start),
	.neg_ref_select(neg_ref_select), .pos_ref_select(pos_ref_select), .pin_analog(pin_analog));
`default_nettype wire

// [sim/adc_ctrl_bench.sv]
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_bench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rv;
	logic pready, pslverr, er, irq, en, start, chv, cal, nref, pref, done, chv_s;
	logic [3:0] ch;
	logic [2:0] acq, clk;
	logic [15:0] pins, pins_s;
	logic [9:0] cres, res;
	int err_count = 0, cmp_count = 0, n;
	always #50 pclk = ~pclk;
	adc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.core_enable(en), .core_start(start), .core_channel(ch), .core_channel_valid(chv),
		.core_calibrate(cal), .neg_ref_select(nref), .pos_ref_select(pref), .acq_time_select(acq),
		.conv_clock_select(clk), .pin_analog(pins), .core_done(done), .core_result(cres));
	adc_ctrl #(.LARGE_PKG(0)) dut_small (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(), .irq(),
		.core_enable(), .core_start(), .core_channel(), .core_channel_valid(chv_s), .core_calibrate(),
		.neg_ref_select(), .pos_ref_select(), .acq_time_select(), .conv_clock_select(),
		.pin_analog(pins_s), .core_done(done), .core_result(cres));
	core_model core (.pclk(pclk), .core_start(start), .core_channel(ch), .core_done(done), .core_result(cres));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rv = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wait_idle;
		n = 0;
		do begin
			bus(0, 8'h00, 0);
			n++;
		end while (rv[1] !== 1'b0 && n < 40);
	endtask
	function automatic logic [15:0] pmask(input int c);
		int ord[15] = '{15, 14, 13, 12, 11, 10, 9, 8, 7, 6, 4, 3, 2, 1, 0};
		int d;
		d = (c == 0) ? 0 : (c <= 9) ? c + 1 : c;
		pmask = 16'h0000;
		for (int i = d; i < 15; i++)
			pmask[ord[i]] = 1'b1;
	endfunction
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#2000000;
		err_count++;
		conclude;
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		bus(0, 8'h00, 0);
		chk(rv, 0);
		chk(pins, 16'hffdf);
		chk(pins_s, 16'h0fdf);
		bus(1, 8'h00, 32'h40);
		bus(0, 8'h00, 0);
		chk(rv, 0);
		bus(1, 8'h04, 32'hff);
		chk({nref, pref}, 2'b11);
		bus(0, 8'h04, 0);
		chk(rv, 32'h3f);
		for (int c = 0; c < 16; c++) begin
			bus(1, 8'h04, c);
			chk(pins, pmask(c));
			chk(pins_s, pmask(c) & 16'h0fff);
		end
		chk({nref, pref}, 2'b00);
		$display("test registers done");
		bus(1, 8'h1c, 1);
		for (int c = 0; c < 16; c++) begin
			res = {c[3:0], 6'h15};
			bus(1, 8'h00, {c[3:0], 2'b11});
			chk(ch, c);
			chk(chv, c != 5 && c <= 12);
			chk(chv_s, c != 5 && c <= 11);
			bus(0, 8'h00, 0);
			chk(rv[1], 1);
			wait_idle;
			chk(rv, {c[3:0], 2'b01});
			chk(irq, 1);
			bus(0, 8'h14, 0);
			chk(rv, 1);
			bus(0, 8'h0c, 0);
			chk(rv, res[9:2]);
			bus(0, 8'h10, 0);
			chk(rv, {res[1:0], 6'h00});
			bus(1, 8'h18, 1);
			chk(irq, 0);
		end
		bus(1, 8'h08, 32'h80);
		bus(0, 8'h0c, 0);
		chk(rv, res[9:8]);
		bus(0, 8'h10, 0);
		chk(rv, res[7:0]);
		bus(1, 8'h08, 32'hff);
		chk({acq, clk}, 6'h3f);
		bus(0, 8'h08, 0);
		chk(rv, 32'hbf);
		$display("test conversions done");
		bus(1, 8'h00, 32'h83);
		chk(cal, 1);
		wait_idle;
		chk(rv, 32'h01);
		chk(cal, 0);
		bus(0, 8'h14, 0);
		chk(rv, 3);
		bus(1, 8'h18, 3);
		bus(1, 8'h00, 32'h03);
		bus(1, 8'h00, 0);
		bus(0, 8'h00, 0);
		chk(rv, 0);
		repeat (10) @(posedge pclk);
		bus(0, 8'h14, 0);
		chk(rv, 0);
		bus(0, 8'h20, 0);
		chk(er, 1);
		chk(rv, 0);
		$display("test calibrate and abort done");
		bus(1, 8'h00, 32'h03);
		presetn <= 1'b0;
		@(posedge pclk);
		chk({en, start}, 2'b00);
		presetn <= 1'b1;
		@(posedge pclk);
		bus(0, 8'h0c, 0);
		chk(rv, 32'h05);
		$display("test reset done");
		conclude;
	end
endmodule // adc_ctrl_bench
`default_nettype wire
